// ==== hdl/ufis_fill_ctr.sv ====
/*
 * Fill counter of one byte FIFO: tracks occupancy, flags full and empty,
 * and reports a push refused because the FIFO is full.
 * Assumes push and pop are one-cycle strobes in the clk domain.
 */
`include "ufis_map.svh"

module ufis_fill_ctr
  import ufis_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events
  input wire logic push,
  input wire logic pop,
  // Status
  output logic [5:0] count,
  output logic full,
  output logic empty,
  output logic overflow
);

  logic [5:0] count_r;
  logic [5:0] count_nxt;
  logic do_push;
  logic do_pop;

  // A pop in the same cycle makes room, so that push is still taken
  assign do_pop = pop & (count_r != 6'h00);
  assign do_push = push & ((count_r != `UFIS_FIFO_DEPTH) | do_pop);
  assign overflow = push & ~do_push;
  assign count_nxt = count_r + {5'h00, do_push} - {5'h00, do_pop};

  // Occupancy register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 6'h00;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
  assign full = (count_r == `UFIS_FIFO_DEPTH);
  assign empty = (count_r == 6'h00);

endmodule // ufis_fill_ctr

// ==== hdl/ufis_map.svh ====
/*
 * Register map, field positions, reset values and fixed sizes of the
 * UART FIFO and interrupt status block.
 * Assumes byte addressing on the register bus, one 32-bit word per register.
 */
`ifndef UFIS_MAP_SVH
`define UFIS_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define UFIS_OFS_FIFO_STS 8'h18
`define UFIS_OFS_INT_STS 8'h1C
`define UFIS_OFS_CTRL 8'h20

// ****************************************************************
// FIFO status fields
// ****************************************************************
`define UFIS_FS_TX_EMPTYF 28
`define UFIS_FS_TX_OVF 24
`define UFIS_FS_TX_FULL 23
`define UFIS_FS_TX_EMPTY 22
`define UFIS_FS_TX_CNT_LO 16
`define UFIS_FS_RX_FULL 15
`define UFIS_FS_RX_EMPTY 14
`define UFIS_FS_RX_CNT_LO 8
`define UFIS_FS_BRK 6
`define UFIS_FS_FE 5
`define UFIS_FS_PE 4
`define UFIS_FS_RX_OVF 0

// ****************************************************************
// Interrupt status fields
// ****************************************************************
`define UFIS_IS_DLIN_INT 31
`define UFIS_IS_DBERR_INT 29
`define UFIS_IS_DTO_INT 28
`define UFIS_IS_DMODEM_INT 27
`define UFIS_IS_DRLS_INT 26
`define UFIS_IS_DLIN_IF 23
`define UFIS_IS_DBERR_IF 21
`define UFIS_IS_DTO_IF 20
`define UFIS_IS_DMODEM_IF 19
`define UFIS_IS_DRLS_IF 18
`define UFIS_IS_BERR_INT 13
`define UFIS_IS_BERR_IF 5
`define UFIS_IS_THRE_IF 1

// ****************************************************************
// Control register fields
// ****************************************************************
`define UFIS_CT_DMA_RX_EN 0
`define UFIS_CT_DMA_TX_EN 1
`define UFIS_CT_BERR_IEN 2
`define UFIS_CT_PAR_EN 3
`define UFIS_CT_PAR_ODD 4

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define UFIS_RST_INT_STS 32'h0000_0002
`define UFIS_RST_FIFO_STS 32'h1040_4000
`define UFIS_RST_CTRL 5'h00
`define UFIS_FIFO_DEPTH 6'h10
`define UFIS_DATA_BITS 4'h8
`define UFIS_FRAME_NOPAR 4'hA
`define UFIS_FRAME_PAR 4'hB

`endif

// ==== hdl/ufis_pkg.sv ====
/*
 * Types shared by the status block and its helpers.
 * Assumes ufis_map.svh supplies all numeric constants.
 */
package ufis_pkg;

  // ****************************************************************
  // Software control bits
  // ****************************************************************
  typedef struct packed {
    logic par_odd;
    logic par_en;
    logic buffer_error_irq_enable;
    logic dma_tx_enable;
    logic dma_rx_enable;
  } ufis_ctrl_s;

  // ****************************************************************
  // Receive line events, each a one-cycle pulse
  // ****************************************************************
  typedef struct packed {
    logic done;
    logic par_err;
    logic frm_err;
    logic brk;
  } ufis_rx_evt_s;

  // Receiver states, one-hot
  typedef enum logic [3:0] {
    UFIS_IDLE = 4'b0001,
    UFIS_DATA = 4'b0010,
    UFIS_PAR = 4'b0100,
    UFIS_STOP = 4'b1000
  } ufis_rx_state_e;

endpackage

// ==== hdl/ufis_rx_chk.sv ====
/*
 * Receive character checker: frames 8 data bits, optional parity and one
 * stop bit, and reports completion, parity, framing and break events.
 * Assumes bit_tick pulses once per bit period at the bit centre.
 */
`include "ufis_map.svh"

module ufis_rx_chk
  import ufis_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line and timing
  input wire logic rx_line,
  input wire logic bit_tick,
  input wire logic par_en,
  input wire logic par_odd,
  // Results
  output ufis_rx_evt_s evt,
  output logic [7:0] rx_byte
);

  ufis_rx_state_e st_r;
  ufis_rx_state_e st_nxt;
  logic [7:0] shf_r;
  logic [3:0] bit_r;
  logic par_r;
  logic [3:0] low_r;
  logic brk_done_r;
  logic [3:0] frame_len;
  logic par_bad;
  logic stop_tick;

  // Frame state sequencing
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      UFIS_IDLE: if (bit_tick && !rx_line) st_nxt = UFIS_DATA;
      UFIS_DATA: if (bit_tick && bit_r == `UFIS_DATA_BITS - 4'h1) st_nxt = par_en ? UFIS_PAR : UFIS_STOP;
      UFIS_PAR: if (bit_tick) st_nxt = UFIS_STOP;
      UFIS_STOP: if (bit_tick) st_nxt = UFIS_IDLE;
    endcase
  end

  assign stop_tick = bit_tick & (st_r == UFIS_STOP);
  assign par_bad = par_en & ((^shf_r ^ par_r) != par_odd);
  assign frame_len = par_en ? `UFIS_FRAME_PAR : `UFIS_FRAME_NOPAR;

  // Shift data LSB first and count bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= UFIS_IDLE;
      shf_r <= 8'h00;
      bit_r <= 4'h0;
      par_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (bit_tick && st_r == UFIS_DATA) begin
        shf_r <= {rx_line, shf_r[7:1]};
        bit_r <= bit_r + 4'h1;
      end else if (st_r == UFIS_IDLE) begin
        bit_r <= 4'h0;
      end
      if (bit_tick && st_r == UFIS_PAR) par_r <= rx_line;
    end
  end

  // Low-time counter: break needs more than one whole frame of space
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_r <= 4'h0;
      brk_done_r <= 1'b0;
    end else if (rx_line) begin
      low_r <= 4'h0;
      brk_done_r <= 1'b0;
    end else if (bit_tick && !brk_done_r) begin
      low_r <= low_r + 4'h1;
      brk_done_r <= (low_r == frame_len); // [RL5]
    end
  end

  // Events are pulses; the received byte is held until the next one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
      rx_byte <= 8'h00;
    end else begin
      evt.done <= stop_tick;
      evt.frm_err <= stop_tick & ~rx_line; // [RL6]
      evt.par_err <= stop_tick & par_bad; // [RL7]
      evt.brk <= bit_tick & ~rx_line & ~brk_done_r & (low_r == frame_len); // [RL5]
      if (stop_tick) rx_byte <= shf_r;
    end
  end

endmodule // ufis_rx_chk

// ==== hdl/ufis_status_top.sv ====
/*
 * UART FIFO and interrupt status block: FIFO fill tracking, receive line
 * error flags, overflow flags and DMA-mode interrupt indicators, with the
 * status reached over an Avalon-MM slave with waitrequest.
 * Assumes the data register, transmit shift register and baud generator sit
 * outside and report their events as one-cycle strobes on clk.
 */
// Added by the designer: the Avalon-MM register port.
// Overview of operation
// RL1: tx count up on write, down on load
// RL2: rx full reads one only when full
// RL3: rx empty sets on last read, clears on receive
// RL4: rx count tracks bytes available to read
// RL5: break flag after low beyond frame time
// RL6: framing flag on stop bit sampled low
// RL7: parity flag on bad parity, write-one clears
// RL8: rx overflow on byte into full FIFO
// RL9: overflow raises buffer error and enabled irq
// RL10: interrupt status at 0x1C resets to 0x2
// RL11: DMA break irq is flag and DMA enable
// RL12: DMA buffer irq is flag and DMA enable
// RL13: DMA timeout irq is flag and DMA enable
// RL14: DMA modem irq is flag and DMA enable
// RL15: DMA line irq is flag and DMA enable
// RL16: DMA break flag set by LIN detect
// RL17: DMA buffer flag follows either overflow flag
// RL18: DMA line flag follows break, framing, parity
// RL19: buffer irq is enable and buffer flag
// RL20: reserved bits read zero, writes ignored
// RL21: zero writes keep flags, read-only ignore writes
`include "ufis_map.svh"

module ufis_status_top
  import ufis_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Transmit path strobes and shift-busy level
  input wire logic tx_wr_stb,
  input wire logic tx_load_stb,
  input wire logic tx_shift_busy,
  // Receive path
  input wire logic rx_rd_stb,
  input wire logic rx_line,
  input wire logic bit_tick,
  output logic [7:0] rx_byte,
  output logic rx_byte_stb,
  // Other event sources
  input wire logic lin_break_det,
  input wire logic rx_timeout_in,
  input wire logic modem_change_in,
  // Interrupt requests
  output logic buffer_error_irq,
  output logic dma_irq
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  logic req;
  logic ack_r;
  logic wr_now;
  logic [31:0] lane_mask;
  logic [31:0] wr_bits;
  logic sel_fifo;
  logic sel_int;
  logic sel_ctrl;
  logic [31:0] rd_mux;

  // One wait state: the answer comes on the cycle after the request
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_now = avs_write & ack_r;

  // Decode on the word address, low two address bits ignored
  assign sel_fifo = (avs_address >> 2 == `UFIS_OFS_FIFO_STS >> 2);
  assign sel_int = (avs_address >> 2 == `UFIS_OFS_INT_STS >> 2);
  assign sel_ctrl = (avs_address >> 2 == `UFIS_OFS_CTRL >> 2);

  // Byte enables widen to a bit mask per lane
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign lane_mask[gl*8 +: 8] = {8{avs_byteenable[gl]}};
    end
  endgenerate

  // Only enabled lanes of the write data can clear anything
  assign wr_bits = avs_writedata & lane_mask;

  // Acknowledge toggles so that a held request is answered once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read data is captured in the wait cycle and stands in the answer cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rd_mux;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************

  ufis_ctrl_s ctrl_r;
  logic dma_en;

  // Byte lane 0 holds every control bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `UFIS_RST_CTRL;
    end else if (wr_now && sel_ctrl && avs_byteenable[0]) begin
      ctrl_r <= avs_writedata[4:0];
    end
  end

  // Either DMA direction arms the DMA-mode indicators
  assign dma_en = ctrl_r.dma_rx_enable | ctrl_r.dma_tx_enable;

  // ****************************************************************
  // FIFO fill tracking
  // ****************************************************************

  logic [5:0] tx_fill_count;
  logic tx_full;
  logic tx_empty;
  logic tx_ovf_evt;
  logic [5:0] rx_fill_count;
  logic rx_fifo_full_flag;
  logic rx_cnt_empty;
  logic rx_ovf_evt;
  ufis_rx_evt_s rx_evt;

  // Transmit occupancy: CPU writes in, shift-register loads out
  ufis_fill_ctr u_tx_fill (
    .clk(clk),
    .rst_n(rst_n),
    .push(tx_wr_stb), // [RL1]
    .pop(tx_load_stb), // [RL1]
    .count(tx_fill_count),
    .full(tx_full),
    .empty(tx_empty),
    .overflow(tx_ovf_evt)
  );

  // Receive occupancy: line bytes in, CPU reads out
  ufis_fill_ctr u_rx_fill (
    .clk(clk),
    .rst_n(rst_n),
    .push(rx_evt.done), // [RL4]
    .pop(rx_rd_stb), // [RL4]
    .count(rx_fill_count),
    .full(rx_fifo_full_flag), // [RL2]
    .empty(rx_cnt_empty),
    .overflow(rx_ovf_evt) // [RL8]
  );

  // Character framing and line checks
  ufis_rx_chk u_rx_chk (
    .clk(clk),
    .rst_n(rst_n),
    .rx_line(rx_line),
    .bit_tick(bit_tick),
    .par_en(ctrl_r.par_en),
    .par_odd(ctrl_r.par_odd),
    .evt(rx_evt),
    .rx_byte(rx_byte)
  );

  assign rx_byte_stb = rx_evt.done;

  // ****************************************************************
  // Receive empty flag
  // ****************************************************************

  logic rx_fifo_empty_flag_r;
  logic rx_fifo_empty_flag_nxt;

  // New data wins over a read of the last byte in the same cycle
  assign rx_fifo_empty_flag_nxt = rx_evt.done ? 1'b0 : // [RL3]
    (rx_rd_stb && rx_fill_count == 6'h01) ? 1'b1 : rx_fifo_empty_flag_r; // [RL3]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_empty_flag_r <= 1'b1;
    end else begin
      rx_fifo_empty_flag_r <= rx_fifo_empty_flag_nxt;
    end
  end

  // ****************************************************************
  // Write-one-to-clear flags
  // ****************************************************************

  logic clr_fifo;
  logic clr_int;
  logic line_break_flag_r;
  logic framing_error_flag_r;
  logic parity_error_flag_r;
  logic rx_overflow_flag_r;
  logic tx_overflow_flag_r;
  logic dma_lin_break_flag_r;
  logic line_break_flag_nxt;
  logic framing_error_flag_nxt;
  logic parity_error_flag_nxt;
  logic rx_overflow_flag_nxt;
  logic tx_overflow_flag_nxt;
  logic dma_lin_break_flag_nxt;

  assign clr_fifo = wr_now & sel_fifo;
  assign clr_int = wr_now & sel_int;

  // Set wins over clear, so an event in the clearing cycle survives
  assign line_break_flag_nxt = rx_evt.brk | // [RL5]
    (line_break_flag_r & ~(clr_fifo & wr_bits[`UFIS_FS_BRK])); // [RL21]
  assign framing_error_flag_nxt = rx_evt.frm_err | // [RL6]
    (framing_error_flag_r & ~(clr_fifo & wr_bits[`UFIS_FS_FE])); // [RL21]
  assign parity_error_flag_nxt = rx_evt.par_err | // [RL7]
    (parity_error_flag_r & ~(clr_fifo & wr_bits[`UFIS_FS_PE])); // [RL21]
  assign rx_overflow_flag_nxt = rx_ovf_evt | // [RL8]
    (rx_overflow_flag_r & ~(clr_fifo & wr_bits[`UFIS_FS_RX_OVF])); // [RL21]
  assign tx_overflow_flag_nxt = tx_ovf_evt |
    (tx_overflow_flag_r & ~(clr_fifo & wr_bits[`UFIS_FS_TX_OVF])); // [RL21]
  assign dma_lin_break_flag_nxt = lin_break_det | // [RL16]
    (dma_lin_break_flag_r & ~(clr_int & wr_bits[`UFIS_IS_DLIN_IF])); // [RL16]

  // Flag registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_break_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      parity_error_flag_r <= 1'b0;
      rx_overflow_flag_r <= 1'b0;
      tx_overflow_flag_r <= 1'b0;
      dma_lin_break_flag_r <= 1'b0;
    end else begin
      line_break_flag_r <= line_break_flag_nxt;
      framing_error_flag_r <= framing_error_flag_nxt;
      parity_error_flag_r <= parity_error_flag_nxt;
      rx_overflow_flag_r <= rx_overflow_flag_nxt;
      tx_overflow_flag_r <= tx_overflow_flag_nxt;
      dma_lin_break_flag_r <= dma_lin_break_flag_nxt;
    end
  end

  // ****************************************************************
  // Derived flags and indicators
  // ****************************************************************

  logic buffer_error_flag;
  logic dma_buffer_error_flag;
  logic dma_line_status_flag;
  logic dma_rx_timeout_flag;
  logic dma_modem_flag;
  logic tx_holding_empty_flag;
  logic dma_lin_break_irq;
  logic dma_buffer_error_irq;
  logic dma_rx_timeout_irq;
  logic dma_modem_irq;
  logic dma_line_status_irq;

  // Level flags follow their sources, so they clear with them
  assign buffer_error_flag = rx_overflow_flag_r | tx_overflow_flag_r; // [RL9]
  assign dma_buffer_error_flag = rx_overflow_flag_r | tx_overflow_flag_r; // [RL17]
  assign dma_line_status_flag = line_break_flag_r | framing_error_flag_r | parity_error_flag_r; // [RL18]
  assign dma_rx_timeout_flag = rx_timeout_in;
  assign dma_modem_flag = modem_change_in;
  assign tx_holding_empty_flag = tx_empty;

  // Indicators gate each flag by its enable
  assign buffer_error_irq = ctrl_r.buffer_error_irq_enable & buffer_error_flag; // [RL9] [RL19]
  assign dma_lin_break_irq = dma_lin_break_flag_r & dma_en; // [RL11]
  assign dma_buffer_error_irq = dma_buffer_error_flag & dma_en; // [RL12]
  assign dma_rx_timeout_irq = dma_rx_timeout_flag & dma_en; // [RL13]
  assign dma_modem_irq = dma_modem_flag & dma_en; // [RL14]
  assign dma_line_status_irq = dma_line_status_flag & dma_en; // [RL15]
  assign dma_irq = dma_lin_break_irq | dma_buffer_error_irq | dma_rx_timeout_irq |
    dma_modem_irq | dma_line_status_irq;

  // ****************************************************************
  // Read-back assembly
  // ****************************************************************

  logic [31:0] fifo_sts;
  logic [31:0] int_sts;
  logic [31:0] ctrl_rd;

  // Unlisted positions stay zero and hold no state
  always_comb begin
    fifo_sts = 32'h0000_0000; // [RL20]
    fifo_sts[`UFIS_FS_TX_EMPTYF] = tx_empty & ~tx_shift_busy;
    fifo_sts[`UFIS_FS_TX_OVF] = tx_overflow_flag_r;
    fifo_sts[`UFIS_FS_TX_FULL] = tx_full;
    fifo_sts[`UFIS_FS_TX_EMPTY] = tx_empty;
    fifo_sts[`UFIS_FS_TX_CNT_LO +: 6] = tx_fill_count; // [RL1]
    fifo_sts[`UFIS_FS_RX_FULL] = rx_fifo_full_flag; // [RL2]
    fifo_sts[`UFIS_FS_RX_EMPTY] = rx_fifo_empty_flag_r; // [RL3]
    fifo_sts[`UFIS_FS_RX_CNT_LO +: 6] = rx_fill_count; // [RL4]
    fifo_sts[`UFIS_FS_BRK] = line_break_flag_r;
    fifo_sts[`UFIS_FS_FE] = framing_error_flag_r;
    fifo_sts[`UFIS_FS_PE] = parity_error_flag_r;
    fifo_sts[`UFIS_FS_RX_OVF] = rx_overflow_flag_r;
  end

  // Only the holding-empty flag is up out of reset
  always_comb begin
    int_sts = 32'h0000_0000; // [RL20]
    int_sts[`UFIS_IS_DLIN_INT] = dma_lin_break_irq;
    int_sts[`UFIS_IS_DBERR_INT] = dma_buffer_error_irq;
    int_sts[`UFIS_IS_DTO_INT] = dma_rx_timeout_irq;
    int_sts[`UFIS_IS_DMODEM_INT] = dma_modem_irq;
    int_sts[`UFIS_IS_DRLS_INT] = dma_line_status_irq;
    int_sts[`UFIS_IS_DLIN_IF] = dma_lin_break_flag_r;
    int_sts[`UFIS_IS_DBERR_IF] = dma_buffer_error_flag;
    int_sts[`UFIS_IS_DTO_IF] = dma_rx_timeout_flag;
    int_sts[`UFIS_IS_DMODEM_IF] = dma_modem_flag;
    int_sts[`UFIS_IS_DRLS_IF] = dma_line_status_flag;
    int_sts[`UFIS_IS_BERR_INT] = buffer_error_irq;
    int_sts[`UFIS_IS_BERR_IF] = buffer_error_flag;
    int_sts[`UFIS_IS_THRE_IF] = tx_holding_empty_flag; // [RL10]
  end

  assign ctrl_rd = {27'h000_0000, ctrl_r};

  // Unmapped addresses read zero and swallow writes
  assign rd_mux = sel_fifo ? fifo_sts :
    sel_int ? int_sts : // [RL10]
    sel_ctrl ? ctrl_rd : 32'h0000_0000; // [RL20]

endmodule // ufis_status_top

// ==== tb/ufis_line_model.sv ====
/* Far-end serial sender: bit ticks and framed characters on the line.
   Assumes the block samples rx_line only on bit_tick edges. */
module ufis_line_model (
  // Clock
  input wire logic clk,
  // Line
  output logic rx_line,
  output logic bit_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_r = 2'h0;
  // ****
  // Tick every fourth cycle, so the block also sees idle cycles
  // ****
  initial rx_line = 1'b1;
  initial bit_tick = 1'b0;
  always @(posedge clk) begin
    div_r <= div_r + 2'h1;
    bit_tick <= (div_r == 2'h3);
  end
  // Level changes just after a tick edge and holds a whole bit
  task automatic put(input logic lvl);
    @(posedge clk iff bit_tick);
    rx_line <= lvl;
    @(posedge clk);
  endtask
  // Start, 8 data LSB first, optional parity, stop, then idle high
  task automatic frame(input logic [7:0] d, input logic pen, input logic pinv, input logic stop);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(d[i]);
    if (pen) put(^d ^ pinv);
    put(stop);
    put(1'b1);
  endtask
  // Line held low for n ticks, then released high
  task automatic low(input int n);
    repeat (n) put(1'b0);
    put(1'b1);
  endtask
endmodule // ufis_line_model

// ==== tb/ufis_status_top_assertions.sv ====
/* Port checker of the status block, bound to ufis_status_top.
   Assumes one clock and an asynchronous active-low reset. */
module ufis_status_top_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Receive and interrupts
  input wire logic bit_tick,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_stb,
  input wire logic buffer_error_irq,
  input wire logic dma_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Properties
  // ****
  property p_wait_one;
    $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
  property p_wait_idle;
    !avs_read && !avs_write |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest while idle");
  property p_rdata_hold;
    !avs_waitrequest |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_stb_tick;
    rx_byte_stb |-> $past(bit_tick);
  endproperty
  a_stb_tick: assert property (p_stb_tick) else $error("byte strobe off tick");
  property p_stb_gap;
    rx_byte_stb |=> !rx_byte_stb [*8];
  endproperty
  a_stb_gap: assert property (p_stb_gap) else $error("byte strobes too close");
  property p_byte_hold;
    !rx_byte_stb |-> $stable(rx_byte);
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte changed without strobe");
  property p_berr_sticky;
    buffer_error_irq && !avs_write |=> buffer_error_irq;
  endproperty
  a_berr_sticky: assert property (p_berr_sticky) else $error("buffer irq dropped");
  property p_irq_reset;
    $rose(rst_n) |-> !dma_irq && !buffer_error_irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq after reset");
endmodule // ufis_status_top_assertions

bind ufis_status_top ufis_status_top_assertions i_ufis_status_top_assertions (.clk, .rst_n,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .bit_tick, .rx_byte, .rx_byte_stb,
  .buffer_error_irq, .dma_irq);

// ==== tb/ufis_status_top_tb.sv ====
/* Self-checking bench of the status block: bus, strobes, serial line.
   Assumes the line model ticks every fourth clock. */
`include "ufis_map.svh"
module ufis_status_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] fs_a = `UFIS_OFS_FIFO_STS;
  localparam logic [7:0] is_a = `UFIS_OFS_INT_STS;
  localparam logic [7:0] ct_a = `UFIS_OFS_CTRL;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] stb = 4'h0;
  logic rx_timeout_in = 1'b0;
  logic modem_change_in = 1'b0;
  logic [31:0] avs_readdata;
  logic [7:0] rx_byte;
  logic avs_waitrequest, rx_line, bit_tick, rx_byte_stb, buffer_error_irq, dma_irq;
  int err_count = 0;
  int checks_done = 0;
  // ****
  // Clock, block and far end
  // ****
  always #25 clk = ~clk;
  ufis_status_top i_ufis_status_top (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .tx_wr_stb(stb[0]),
    .tx_load_stb(stb[1]), .tx_shift_busy(1'b0), .rx_rd_stb(stb[2]), .rx_line, .bit_tick,
    .rx_byte, .rx_byte_stb, .lin_break_det(stb[3]), .rx_timeout_in, .modem_change_in,
    .buffer_error_irq, .dma_irq);
  ufis_line_model i_ufis_line_model (.clk, .rx_line, .bit_tick);
  // Request held until waitrequest is seen low, then one idle cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    bus(a, 1'b0, 32'h0000_0000, d);
    chk(d & m, e);
  endtask
  // One-cycle strobes with an idle cycle between them
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      stb <= m;
      @(posedge clk);
      stb <= 4'h0;
      @(posedge clk);
    end
  endtask
  task automatic t_reset();
    rd_chk(is_a, 32'hFFFF_FFFF, 32'h0000_0002);
    rd_chk(fs_a, 32'hFFFF_FFFF, 32'h1040_4000);
    rd_chk(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(is_a, 32'hFFFF_FFFF);
    rd_chk(is_a, 32'hFFFF_FFFF, 32'h0000_0002);
  endtask
  task automatic t_tx();
    wr(ct_a, 32'h0000_0006);
    pulse(4'h1, 3);
    rd_chk(fs_a, 32'h003F_0000, 32'h0003_0000);
    pulse(4'h2, 1);
    rd_chk(fs_a, 32'h003F_0000, 32'h0002_0000);
    pulse(4'h1, 15);
    rd_chk(fs_a, 32'h01BF_0000, 32'h0190_0000);
    rd_chk(is_a, 32'h2020_2020, 32'h2020_2020);
    chk(dma_irq, 1'b1);
    wr(fs_a, 32'h00FF_FFFF);
    chk(buffer_error_irq, 1'b1);
    wr(fs_a, 32'h0100_0000);
    rd_chk(is_a, 32'h2020_2020, 32'h0000_0000);
    chk(buffer_error_irq, 1'b0);
    pulse(4'h2, 16);
  endtask
  task automatic t_rx();
    i_ufis_line_model.frame(8'hA5, 1'b0, 1'b0, 1'b1);
    rd_chk(fs_a, 32'h0000_FF71, 32'h0000_0100);
    chk(rx_byte, 8'hA5);
    pulse(4'h4, 2);
    rd_chk(fs_a, 32'h0000_FF00, 32'h0000_4000);
    for (int i = 0; i < 16; i++) i_ufis_line_model.frame(8'(i), 1'b0, 1'b0, 1'b1);
    rd_chk(fs_a, 32'h0000_FF01, 32'h0000_9000);
    i_ufis_line_model.frame(8'h5A, 1'b0, 1'b0, 1'b1);
    rd_chk(fs_a, 32'h0000_FF01, 32'h0000_9001);
    rd_chk(is_a, 32'h2020_2020, 32'h2020_2020);
    pulse(4'h4, 1);
    rd_chk(fs_a, 32'h0000_FF00, 32'h0000_0F00);
    wr(fs_a, 32'h0000_0001);
    pulse(4'h4, 15);
  endtask
  task automatic t_err();
    wr(ct_a, 32'h0000_0009);
    i_ufis_line_model.frame(8'h3C, 1'b1, 1'b1, 1'b1);
    rd_chk(fs_a, 32'h0000_0070, 32'h0000_0010);
    rd_chk(is_a, 32'h0404_0000, 32'h0404_0000);
    i_ufis_line_model.frame(8'h3C, 1'b1, 1'b0, 1'b0);
    rd_chk(fs_a, 32'h0000_0070, 32'h0000_0030);
    wr(fs_a, 32'h0000_0070);
    wr(ct_a, 32'h0000_0019);
    i_ufis_line_model.frame(8'h3C, 1'b1, 1'b1, 1'b1);
    rd_chk(fs_a, 32'h0000_0070, 32'h0000_0000);
    wr(ct_a, 32'h0000_0001);
    i_ufis_line_model.low(10);
    rd_chk(fs_a, 32'h0000_0070, 32'h0000_0020);
    i_ufis_line_model.low(11);
    rd_chk(fs_a, 32'h0000_0070, 32'h0000_0060);
    wr(fs_a, 32'h0000_0071);
    rd_chk(is_a, 32'h0404_0000, 32'h0000_0000);
  endtask
  task automatic t_dma();
    pulse(4'h8, 1);
    rd_chk(is_a, 32'h8080_0000, 32'h8080_0000);
    wr(is_a, 32'h0080_0000);
    rd_chk(is_a, 32'h8080_0000, 32'h0000_0000);
    rx_timeout_in <= 1'b1;
    modem_change_in <= 1'b1;
    wr(ct_a, 32'h0000_0002);
    rd_chk(is_a, 32'h1818_0000, 32'h1818_0000);
    wr(ct_a, 32'h0000_0000);
    rd_chk(is_a, 32'h1818_0000, 32'h0018_0000);
    chk(dma_irq, 1'b0);
  endtask
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_dma();
    close_out();
  end
  // Run needs about 1300 cycles; allow 20000
  initial begin
    #1_000_000;
    err_count++;
    close_out();
  end
endmodule // ufis_status_top_tb
